// ===== sdb_consts.vh
// constants for the scan-data buffer controller
//
// Behaviour
// - ring mode overwrites the oldest record once full; storing never stops.
// - fifo mode takes log, monitor, single records and forwards them in order.
// - fifo mode holds off measurement while full until draining frees space.
// - store control acts only in fix or ring mode, ignored in fifo.
// - store control sets store-active; records are accepted while it is set.
// - monitor scan records are not written when monitor storing is off.
// - fix mode full clears store-active and stops writing; measurement goes on.
// - fix/ring capacity M: (N*7+16)*(M+2) = 524288.
// - fifo capacity M: (N*12+13)*(M+1) = 524288.
// - recall control in fix/ring sets recall-active, sends range to enabled outputs.
// - recall control during recall clears recall-active and ends at once.
// - recall range runs start to stop; in fix mode each bound is session count plus log number.
// - fix mode recall selects by log numbers assigned at measurement.
// - ring mode recall numbers records serially, oldest is 000001.
// - buffer clear zeroes session count; start/stop with store-active adds one.
// - session count unchanged on start/stop while store-active is clear.
// - session count saturates at 9; only buffer clear returns it to zero.
// - log number starts at 00001 and increments on every log scan up to 99999.
// - log number does not change on monitor scans.
// - range 9/1 to 9/99999 returns every set stored at session count 9.
// - keep count of log scans stored and of log plus monitor scans stored.
// - fix mode never overwrites stored records; only buffer clear or a change of mode or channel count removes them.
`ifndef SDB_CONSTS_VH
`define SDB_CONSTS_VH

// storage modes
`define SDB_MODE_FIX      2'h0
`define SDB_MODE_RING     2'h1
`define SDB_MODE_FIFO     2'h2
// record kinds
`define SDB_KIND_LOG      2'h0
`define SDB_KIND_MON      2'h1
`define SDB_KIND_SINGLE   2'h2
// capacity arithmetic
`define SDB_MEM_BYTES     20'h80000
`define SDB_FIX_CH_MUL    14'h0007
`define SDB_FIX_CH_ADD    14'h0010
`define SDB_FIX_OVH       16'h0002
`define SDB_FIFO_CH_MUL   14'h000C
`define SDB_FIFO_CH_ADD   14'h000D
`define SDB_FIFO_OVH      16'h0001
// counters
`define SDB_SESSION_MAX   4'h9
`define SDB_LOG_FIRST     17'h00001
`define SDB_LOG_MAX       17'h1869F
`define SDB_COUNT_MAX     16'hFFFF
// entry layout
`define SDB_ADDR_W        15
`define SDB_ENTRY_W       39
`define SDB_F_DATA_HI     15
`define SDB_F_KIND_LO     16
`define SDB_F_KIND_HI     17
`define SDB_F_LOG_LO      18
`define SDB_F_LOG_HI      34
`define SDB_F_SESS_LO     35
`define SDB_F_SESS_HI     38

`endif

// ===== sdb_mem.v
// record memory with one write port and a registered read port
`timescale 1ns/1ps
`default_nettype none
`include "sdb_consts.vh"

module sdb_mem (
   input  wire                      clock,
   input  wire                      wr_en,
   input  wire [`SDB_ADDR_W-1:0]    wr_addr,
   input  wire [`SDB_ENTRY_W-1:0]   wr_data,
   input  wire [`SDB_ADDR_W-1:0]    rd_addr,
   output reg  [`SDB_ENTRY_W-1:0]   rd_data
);

   reg [`SDB_ENTRY_W-1:0] store [0:(1<<`SDB_ADDR_W)-1];

   // write and registered read, read returns old data on collision
   always @(posedge clock) begin
      if (wr_en) begin
         store[wr_addr] <= wr_data;
      end
      rd_data <= store[rd_addr];
   end

endmodule
`default_nettype wire

// ===== sdb_ctrl.v
// scan-data buffer controller: storage, capacity, counters, recall and fifo drain
`timescale 1ns/1ps
`default_nettype none
`include "sdb_consts.vh"

module sdb_ctrl (
   input  wire          clock,
   input  wire          sys_rst,
   input  wire [1:0]    mode,
   input  wire [9:0]    chan_count,
   input  wire          mon_store_en,
   input  wire          store_key,
   input  wire          recall_key,
   input  wire          buf_clear,
   input  wire          meas_startstop,
   input  wire [3:0]    recall_start_times,
   input  wire [16:0]   recall_start_num,
   input  wire [3:0]    recall_stop_times,
   input  wire [16:0]   recall_stop_num,
   input  wire          gpib_en,
   input  wire          printer_en,
   input  wire          scan_valid,
   input  wire [1:0]    scan_kind,
   input  wire [15:0]   scan_data,
   output wire          scan_ready,
   output wire          out_valid,
   input  wire          out_ready,
   output reg  [15:0]   out_data,
   output reg  [1:0]    out_kind,
   output reg  [3:0]    out_times,
   output reg  [16:0]   out_lognum,
   output reg           out_to_gpib,
   output reg           out_to_printer,
   output reg           store_active,
   output reg           recall_active,
   output reg  [3:0]    session_count,
   output reg  [16:0]   log_number,
   output reg  [15:0]   log_stored,
   output reg  [15:0]   total_stored,
   output wire          buf_full,
   output reg           calc_busy,
   output reg  [15:0]   capacity
);

   // sequencer states
   localparam S_IDLE = 2'h0;
   localparam S_READ = 2'h1;
   localparam S_EVAL = 2'h2;
   localparam S_SEND = 2'h3;

   // configuration in force, capacity division and buffer state
   reg  [1:0]                cfg_mode;
   reg  [9:0]                cfg_chan;
   reg  [19:0]               calc_rem;
   reg  [15:0]               calc_cnt;
   reg  [`SDB_ADDR_W-1:0]    wr_ptr;
   reg  [`SDB_ADDR_W-1:0]    rd_ptr;
   reg  [15:0]               count;
   reg  [1:0]                state;
   reg  [`SDB_ADDR_W-1:0]    rec_addr;
   reg  [15:0]               rec_idx;
   reg                       drain;

   // decode, handshake and recall nets
   wire [`SDB_ENTRY_W-1:0]   rd_data;
   wire [9:0]                chan_eff;
   wire [13:0]               chan_wide;
   wire [13:0]               cost;
   wire                      cfg_chg;
   wire                      wipe;
   wire                      is_fix;
   wire                      is_ring;
   wire                      is_fifo;
   wire                      want_store;
   wire                      scan_fire;
   wire                      do_write;
   wire                      wr_inc;
   wire                      pop;
   wire                      rec_next_end;
   wire [`SDB_ADDR_W-1:0]    next_wr_ptr;
   wire [`SDB_ADDR_W-1:0]    next_rd_ptr;
   wire [`SDB_ADDR_W-1:0]    next_rec_addr;
   wire [15:0]               next_rec_idx;
   wire [20:0]               key_rec;
   wire [20:0]               key_lo;
   wire [20:0]               key_hi;
   wire                      any_out;

   // the mode in force is the one the capacity was computed for
   assign is_fix  = (cfg_mode == `SDB_MODE_FIX);
   assign is_ring = (cfg_mode == `SDB_MODE_RING);
   assign is_fifo = (cfg_mode == `SDB_MODE_FIFO);

   // per-scan byte cost; zero channels is treated as one
   assign chan_eff = (cfg_chan == 10'h000) ? 10'h001 : cfg_chan;
   // 14 bits: the fifo cost reaches 12289 at 1023 channels
   assign chan_wide = {4'h0, chan_eff};
   assign cost      = is_fifo ? (chan_wide * `SDB_FIFO_CH_MUL + `SDB_FIFO_CH_ADD)
                              : (chan_wide * `SDB_FIX_CH_MUL + `SDB_FIX_CH_ADD);

   // a change of mode or channel count invalidates the layout, so it wipes too
   assign cfg_chg = (mode != cfg_mode) | (chan_count != cfg_chan);
   assign wipe    = buf_clear | cfg_chg;

   // capacity by repeated subtraction of the per-scan cost from the memory size
   always @(posedge clock) begin
      if (sys_rst) begin
         cfg_mode  <= `SDB_MODE_FIX;
         cfg_chan  <= 10'h000;
         calc_busy <= 1'b1;
         calc_rem  <= `SDB_MEM_BYTES;
         calc_cnt  <= 16'h0000;
         capacity  <= 16'h0000;
      end else if (cfg_chg) begin
         // restart the division for the new layout
         cfg_mode  <= mode;
         cfg_chan  <= chan_count;
         calc_busy <= 1'b1;
         calc_rem  <= `SDB_MEM_BYTES;
         calc_cnt  <= 16'h0000;
      // one subtraction per clock until the remainder is short
      end else if (calc_busy) begin
         if (calc_rem >= {6'h00, cost}) begin
            calc_rem <= calc_rem - {6'h00, cost};
            calc_cnt <= calc_cnt + 16'h0001;
         end else begin
            calc_busy <= 1'b0;
            capacity  <= calc_cnt - (is_fifo ? `SDB_FIFO_OVH : `SDB_FIX_OVH);
         end
      end
   end

   // full is only meaningful once the capacity is known
   assign buf_full = (count == capacity) & ~calc_busy;

   // fifo mode stores every kind; fix and ring only while store-active; monitor scans only with mon_store_en
   assign want_store = (is_fifo | store_active)
                     & ~((scan_kind == `SDB_KIND_MON) & ~mon_store_en);
   // a scan at a layout-change edge would be wiped, so it is held off
   assign scan_ready = ~calc_busy & ~cfg_chg & ~(is_fifo & buf_full);
   assign scan_fire  = scan_valid & scan_ready;
   assign do_write   = scan_fire & want_store & ~(is_fix & buf_full);
   // a full ring write replaces a record, so the count holds
   assign wr_inc     = do_write & ~(is_ring & buf_full);
   // a fifo record leaves when the sink takes it
   assign pop        = (state == S_SEND) & out_ready & drain;

   // pointers wrap at the capacity, not at the memory depth
   assign next_wr_ptr = (wr_ptr == capacity[`SDB_ADDR_W-1:0] - 1'b1) ? {`SDB_ADDR_W{1'b0}}
                                                                     : wr_ptr + 1'b1;
   assign next_rd_ptr = (rd_ptr == capacity[`SDB_ADDR_W-1:0] - 1'b1) ? {`SDB_ADDR_W{1'b0}}
                                                                     : rd_ptr + 1'b1;

   // write position, oldest position and fill count
   always @(posedge clock) begin
      if (sys_rst | wipe) begin
         wr_ptr <= {`SDB_ADDR_W{1'b0}};
         rd_ptr <= {`SDB_ADDR_W{1'b0}};
         count  <= 16'h0000;
      end else begin
         if (do_write) begin
            wr_ptr <= next_wr_ptr;
         end
         // full ring write lands on the oldest, which moves on
         if ((do_write & is_ring & buf_full) | pop) begin
            rd_ptr <= next_rd_ptr;
         end
         // fill count follows writes and fifo pops
         if (wr_inc & ~pop) begin
            count <= count + 16'h0001;
         end else if (pop & ~wr_inc) begin
            count <= count - 16'h0001;
         end
      end
   end

   // store-active indicator
   always @(posedge clock) begin
      if (sys_rst) begin
         store_active <= 1'b0;
      end else if (is_fifo) begin
         store_active <= 1'b0;
      // a full fix buffer keeps it clear even against the key
      end else if (is_fix & buf_full) begin
         store_active <= 1'b0;
      end else if (store_key) begin
         store_active <= ~store_active;
      end
   end

   // session count
   always @(posedge clock) begin
      if (sys_rst | buf_clear) begin
         session_count <= 4'h0;
      // saturates at nine; only buffer clear lowers it
      end else if (meas_startstop & store_active & (session_count != `SDB_SESSION_MAX)) begin
         session_count <= session_count + 4'h1;
      end
   end

   // log number restarts at each start/stop; single scans leave it
   always @(posedge clock) begin
      if (sys_rst | buf_clear | meas_startstop) begin
         log_number <= `SDB_LOG_FIRST;
      end else if (scan_fire & (scan_kind == `SDB_KIND_LOG) & (log_number != `SDB_LOG_MAX)) begin
         log_number <= log_number + 17'h00001;
      end
   end

   // stored-scan counts for the storage display
   always @(posedge clock) begin
      if (sys_rst | wipe) begin
         log_stored   <= 16'h0000;
         total_stored <= 16'h0000;
      end else if (do_write) begin
         if ((scan_kind == `SDB_KIND_LOG) & (log_stored != `SDB_COUNT_MAX)) begin
            log_stored <= log_stored + 16'h0001;
         end
         if ((scan_kind != `SDB_KIND_SINGLE) & (total_stored != `SDB_COUNT_MAX)) begin
            total_stored <= total_stored + 16'h0001;
         end
      end
   end

   // each entry keeps session and log number beside the data
   sdb_mem sdb_mem_inst (
      .clock   (clock),
      .wr_en   (do_write),
      .wr_addr (wr_ptr),
      .wr_data ({session_count, log_number, scan_kind, scan_data}),
      .rd_addr (rec_addr),
      .rd_data (rd_data)
   );

   // recall keys: fix uses session and log number, ring the serial from the oldest
   assign key_rec = is_ring ? {4'h0, rec_idx + 17'h00001}
                            : rd_data[`SDB_F_SESS_HI:`SDB_F_LOG_LO];
   // range bounds; ring ignores the session count
   assign key_lo  = is_ring ? {4'h0, recall_start_num}
                            : {recall_start_times, recall_start_num};
   assign key_hi  = is_ring ? {4'h0, recall_stop_num}
                            : {recall_stop_times, recall_stop_num};
   assign any_out = gpib_en | printer_en;

   // next record to read during a recall
   assign next_rec_idx  = rec_idx + 16'h0001;
   assign next_rec_addr = (rec_addr == capacity[`SDB_ADDR_W-1:0] - 1'b1) ? {`SDB_ADDR_W{1'b0}}
                                                                         : rec_addr + 1'b1;
   assign rec_next_end  = (next_rec_idx >= count);

   // a record is presented only while sending
   assign out_valid     = (state == S_SEND);

   // recall and fifo drain sequencer sharing the memory read port
   always @(posedge clock) begin
      if (sys_rst | wipe) begin
         state          <= S_IDLE;
         recall_active  <= 1'b0;
         drain          <= 1'b0;
         rec_addr       <= {`SDB_ADDR_W{1'b0}};
         rec_idx        <= 16'h0000;
         out_data       <= 16'h0000;
         out_kind       <= 2'h0;
         out_times      <= 4'h0;
         out_lognum     <= 17'h00000;
         out_to_gpib    <= 1'b0;
         out_to_printer <= 1'b0;
      end else if (recall_active & recall_key) begin
         // second key ends the recall at once
         recall_active  <= 1'b0;
         state          <= S_IDLE;
      end else begin
         case (state)
            // idle: start a fifo drain or a recall
            S_IDLE: begin
               rec_addr <= rd_ptr;
               rec_idx  <= 16'h0000;
               if (is_fifo & ~calc_busy & (count != 16'h0000)) begin
                  drain <= 1'b1;
                  state <= S_READ;
               end else if (~is_fifo & ~calc_busy & recall_key) begin
                  drain <= 1'b0;
                  if (count != 16'h0000) begin
                     recall_active <= 1'b1;
                     state         <= S_READ;
                  end
               end
            end
            // read: the memory read port loads this cycle
            S_READ: begin
               state <= S_EVAL;
            end
            // eval: latch the record, then send, skip or stop
            S_EVAL: begin
               out_data   <= rd_data[`SDB_F_DATA_HI:0];
               out_kind   <= rd_data[`SDB_F_KIND_HI:`SDB_F_KIND_LO];
               out_times  <= rd_data[`SDB_F_SESS_HI:`SDB_F_SESS_LO];
               out_lognum <= is_ring ? rec_idx + 17'h00001 : rd_data[`SDB_F_LOG_HI:`SDB_F_LOG_LO];
               out_to_gpib    <= gpib_en;
               out_to_printer <= printer_en;
               // fifo records always go out; recall tests the range
               if (drain) begin
                  state <= S_SEND;
               end else if (key_rec > key_hi) begin
                  recall_active <= 1'b0;
                  state         <= S_IDLE;
               end else if ((key_rec >= key_lo) & any_out) begin
                  state <= S_SEND;
               end else if (rec_next_end) begin
                  recall_active <= 1'b0;
                  state         <= S_IDLE;
               end else begin
                  rec_idx  <= next_rec_idx;
                  rec_addr <= next_rec_addr;
                  state    <= S_READ;
               end
            end
            // send: hold the record until the sink takes it
            S_SEND: begin
               if (out_ready) begin
                  if (drain) begin
                     drain <= 1'b0;
                     state <= S_IDLE;
                  end else if (rec_next_end | (key_rec == key_hi)) begin
                     recall_active <= 1'b0;
                     state         <= S_IDLE;
                  end else begin
                     rec_idx  <= next_rec_idx;
                     rec_addr <= next_rec_addr;
                     state    <= S_READ;
                  end
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// ===== sdb_ctrl_assertions.sv
// checker for the scan-data buffer controller ports
`timescale 1ns/1ps
`default_nettype none
module sdb_chk (
   input wire logic        clock,
   input wire logic        sys_rst,
   input wire logic [1:0]  mode,
   input wire logic        mon_store_en,
   input wire logic        store_key,
   input wire logic        recall_key,
   input wire logic        buf_clear,
   input wire logic        meas_startstop,
   input wire logic        scan_valid,
   input wire logic [1:0]  scan_kind,
   input wire logic        scan_ready,
   input wire logic        out_valid,
   input wire logic        store_active,
   input wire logic        recall_active,
   input wire logic [3:0]  session_count,
   input wire logic [16:0] log_number,
   input wire logic [15:0] total_stored,
   input wire logic        buf_full
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   // a scan of kind k taken with no counter-resetting pulse beside it
   sequence s_take(k);
      scan_valid && scan_ready && scan_kind == k && !buf_clear && !meas_startstop;
   endsequence
   a_store_toggle: assert property (
      store_key && mode != 2'h2 && !buf_full |=> store_active != $past(store_active))
      else $error("store key did not toggle store active");
   a_store_fifo: assert property (store_key && mode == 2'h2 |=> $stable(store_active))
      else $error("store key acted in fifo mode");
   a_fix_full: assert property (mode == 2'h0 && buf_full |=> !store_active)
      else $error("store active kept while fix buffer full");
   a_fifo_holdoff: assert property (mode == 2'h2 && buf_full |-> !scan_ready)
      else $error("scan accepted while fifo full");
   a_sess_step: assert property (
      meas_startstop && !buf_clear && store_active && session_count < 4'h9
      |=> session_count == $past(session_count) + 4'h1) else $error("session count did not step");
   a_sess_hold: assert property (
      meas_startstop && !buf_clear && (!store_active || session_count == 4'h9) |=> $stable(session_count))
      else $error("session count moved");
   a_log_step: assert property (s_take(2'h0) ##0 log_number < 17'h1869F
      |=> log_number == $past(log_number) + 17'h1) else $error("log number did not step");
   a_log_mon: assert property (s_take(2'h1) |=> $stable(log_number))
      else $error("log number moved on monitor scan");
   a_mon_off: assert property (s_take(2'h1) ##0 !mon_store_en && mode != 2'h2
      |=> $stable(total_stored)) else $error("monitor scan stored while off");
   a_recall_abort: assert property (recall_key && recall_active |=> !recall_active && !out_valid)
      else $error("recall not ended by second key");
   a_clear_all: assert property (buf_clear
      |=> session_count == 4'h0 && log_number == 17'h1 && total_stored == 16'h0 && !recall_active)
      else $error("buffer clear incomplete");
endmodule
bind sdb_ctrl sdb_chk sdb_chk_inst (.clock, .sys_rst, .mode, .mon_store_en, .store_key, .recall_key,
   .buf_clear, .meas_startstop, .scan_valid, .scan_kind, .scan_ready, .out_valid, .store_active,
   .recall_active, .session_count, .log_number, .total_stored, .buf_full);
`default_nettype wire

// ===== sdb_partner.sv
// far-side model: scanner offering records and output sink taking them
`timescale 1ns/1ps
`default_nettype none
module sdb_partner (
   input  wire logic        clock,
   input  wire logic        hold,
   input  wire logic        scan_ready,
   input  wire logic        out_valid,
   input  wire logic [15:0] out_data,
   output var  logic        scan_valid,
   output var  logic [1:0]  scan_kind,
   output var  logic [15:0] scan_data,
   output var  logic        out_ready
);
   logic [15:0] got[$];
   initial begin
      scan_valid = 1'b0;
      scan_kind  = 2'h0;
      scan_data  = 16'h0000;
      out_ready  = 1'b0;
   end
   // sink stalls at random, fully while hold is set
   always @(negedge clock) out_ready <= !hold && ($urandom_range(1, 0) == 1);
   // records handed over at an edge with valid and ready
   always @(posedge clock) if (out_valid && out_ready) got.push_back(out_data);
   // offer one record from a falling edge, held until taken
   task send(input logic [1:0] k, input logic [15:0] d);
      scan_valid = 1'b1;
      scan_kind  = k;
      scan_data  = d;
      while (scan_ready !== 1'b1) @(negedge clock);
      @(negedge clock);
   endtask
   // released data lines show the inverse of the last value
   task idle;
      scan_valid = 1'b0;
      scan_data  = ~scan_data;
      @(negedge clock);
   endtask
endmodule
`default_nettype wire

// ===== tb_sdb_ctrl.sv
// self-checking testbench for the scan-data buffer controller
`timescale 1ns/1ps
`default_nettype none
module tb_sdb_ctrl;
   logic        clock, sys_rst, mon_store_en, store_key, recall_key, buf_clear, meas_startstop;
   logic        gpib_en, printer_en, hold, scan_valid, scan_ready, out_valid, out_ready;
   logic        store_active, recall_active, buf_full, calc_busy, out_to_gpib, out_to_printer;
   logic [1:0]  mode, scan_kind, out_kind;
   logic [9:0]  chan_count;
   logic [3:0]  recall_start_times, recall_stop_times, session_count, out_times;
   logic [16:0] recall_start_num, recall_stop_num, log_number, out_lognum;
   logic [15:0] scan_data, out_data, log_stored, total_stored, capacity, d;
   logic [15:0] q[$];
   int          n_errors, samples_checked, cycles, i, cap;
   sdb_ctrl sdb_ctrl_inst (.clock, .sys_rst, .mode, .chan_count, .mon_store_en, .store_key, .recall_key,
      .buf_clear, .meas_startstop, .recall_start_times, .recall_start_num, .recall_stop_times,
      .recall_stop_num, .gpib_en, .printer_en, .scan_valid, .scan_kind, .scan_data, .scan_ready, .out_valid,
      .out_ready, .out_data, .out_kind, .out_times, .out_lognum, .out_to_gpib, .out_to_printer,
      .store_active, .recall_active, .session_count, .log_number, .log_stored, .total_stored, .buf_full,
      .calc_busy, .capacity);
   sdb_partner partner_inst (.clock, .hold, .scan_ready, .out_valid, .out_data, .scan_valid, .scan_kind,
      .scan_data, .out_ready);
   // capacity in scans for a mode at the current channel count
   function automatic int exp_cap(input logic [1:0] m);
      if (m == 2'h2) return 524288 / (int'(chan_count) * 12 + 13) - 1;
      return 524288 / (int'(chan_count) * 7 + 16) - 2;
   endfunction
   task chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clock);
      s = 1'b0;
      @(negedge clock);
   endtask
   // wait out the capacity calculation after reset or a mode change
   task wait_calc;
      repeat (3) @(negedge clock);
      while (calc_busy !== 1'b0) @(negedge clock);
      cap = exp_cap(mode);
   endtask
   // n random records of kind k, kind 3 meaning any kind
   task fill(input int n, input logic [1:0] k);
      for (int j = 0; j < n; j++) begin
         d = 16'($urandom);
         partner_inst.send((k == 2'h3) ? 2'($urandom_range(2, 0)) : k, d);
         q.push_back(d);
      end
      partner_inst.idle;
   endtask
   // recall keys ts/ns to ts/ne, expect n records equal to q from index a
   task take_recall(input logic [3:0] ts, input logic [16:0] ns, input logic [16:0] ne, input int a,
                    input int n);
      recall_start_times = ts;
      recall_start_num = ns;
      recall_stop_times = ts;
      recall_stop_num = ne;
      pulse(recall_key);
      while (recall_active !== 1'b0) @(negedge clock);
      chk(partner_inst.got.size(), n);
      for (int j = 0; j < n; j++) chk(partner_inst.got[j], q[a + j]);
      chk({out_kind, out_to_gpib, out_to_printer}, {2'h0, gpib_en, printer_en});
      partner_inst.got.delete();
   endtask
   task print_verdict;
      $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // hang guard
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         print_verdict;
      end
   end
   initial begin
      void'($urandom(41));
      {mode, mon_store_en, store_key, recall_key, buf_clear, meas_startstop, hold} = '0;
      {recall_start_times, recall_start_num, recall_stop_times, recall_stop_num} = '0;
      chan_count = 10'h3FF;
      gpib_en = 1'b1;
      printer_en = 1'b0;
      sys_rst = 1'b1;
      repeat (6) @(negedge clock);
      sys_rst = 1'b0;
      // fix: store, fill past full, recall a middle range
      wait_calc;
      chk(capacity, cap);
      chk(log_number, 17'h1);
      pulse(store_key);
      chk(store_active, 1'b1);
      pulse(meas_startstop);
      chk(session_count, 4'h1);
      partner_inst.send(2'h1, 16'h5A5A);
      fill(cap + 3, 2'h0);
      chk(store_active, 1'b0);
      chk(log_stored, cap);
      chk(total_stored, cap);
      take_recall(4'h1, 17'h3, 17'h5, 2, 3);
      chk({out_times, out_lognum}, {4'h1, 17'h5});
      // abort a recall two cycles after it starts, before any record reaches the held sink
      hold = 1'b1;
      recall_stop_times = 4'h9;
      pulse(recall_key);
      chk(recall_active, 1'b1);
      pulse(recall_key);
      chk(recall_active, 1'b0);
      hold = 1'b0;
      partner_inst.got.delete();
      $display("fix test done");
      // session counter: clear, hold while off, saturate
      pulse(buf_clear);
      chk(total_stored, 16'h0);
      pulse(meas_startstop);
      chk(session_count, 4'h0);
      pulse(store_key);
      for (i = 1; i <= 11; i++) begin
         pulse(meas_startstop);
         chk(session_count, (i < 9) ? i : 9);
      end
      // two sets stored at the saturated session count
      q.delete();
      fill(2, 2'h0);
      pulse(meas_startstop);
      fill(2, 2'h0);
      take_recall(4'h9, 17'h1, 17'h1869F, 0, 4);
      chk({out_times, out_lognum}, {4'h9, 17'h2});
      pulse(store_key);
      $display("session test done");
      // ring: counts, overwrite of oldest, serial recall to printer
      mode = 2'h1;
      wait_calc;
      if (store_active !== 1'b1) pulse(store_key);
      mon_store_en = 1'b1;
      partner_inst.send(2'h1, 16'h0001);
      fill(3, 2'h0);
      partner_inst.send(2'h1, 16'h0002);
      partner_inst.idle;
      chk(log_stored, 16'h3);
      chk(total_stored, 16'h5);
      pulse(buf_clear);
      q.delete();
      fill(cap + 5, 2'h0);
      gpib_en = 1'b0;
      printer_en = 1'b1;
      take_recall(4'h0, 17'h2, 17'h4, 6, 3);
      chk(out_lognum, 17'h4);
      $display("ring test done");
      // fifo: fill to full with sink held, then drain in order
      mode = 2'h2;
      wait_calc;
      chk(capacity, cap);
      pulse(store_key);
      chk(store_active, 1'b0);
      q.delete();
      hold = 1'b1;
      fill(cap, 2'h3);
      repeat (3) @(negedge clock);
      chk(scan_ready, 1'b0);
      hold = 1'b0;
      fill(6, 2'h3);
      while (partner_inst.got.size() < q.size()) @(negedge clock);
      for (i = 0; i < q.size(); i++) chk(partner_inst.got[i], q[i]);
      $display("fifo test done");
      print_verdict;
   end
endmodule
`default_nettype wire
